// ==== logic/motor_fault_defines.svh ====
`ifndef MOTOR_FAULT_DEFINES_SVH
`define MOTOR_FAULT_DEFINES_SVH

`define CLK_PERIOD_NS 4
`define TICK_NS       100000000
`define TICK_MS       100
`define AUX_OPEN_MS   400

`define ADDR_CTRL     8'h00
`define ADDR_XFMR     8'h04
`define ADDR_STARTER  8'h08
`define ADDR_FLA1     8'h0C
`define ADDR_FLA2     8'h10
`define ADDR_GROUND   8'h14
`define ADDR_JAM      8'h18
`define ADDR_STALL    8'h1C
`define ADDR_UNBAL    8'h20
`define ADDR_LOAD     8'h24
`define ADDR_AUX      8'h28
`define ADDR_STATUS   8'h2C
`define ADDR_METER    8'h30

`define F_CTRL_CFG    0
`define F_CTRL_RUN    1
`define F_CTRL_RUN2   2
`define F_CTRL_CLR    3
`define F_XF_CPT      0
`define F_XF_CT       4
`define F_XF_TURNS    8
`define F_DLY         16

`define RST_CPT_SEL     4'h1
`define RST_CT_SEL      4'h3
`define RST_FLA         13'h03E8
`define RST_GF_DLY      5'h05
`define RST_JAM_DLY     8'h18
`define RST_STALL_DLY   6'h14
`define RST_UNBAL_DLY   8'h05
`define RST_LOAD_DLY    8'h3C
`define RST_AUX_DLY     8'h04

`define FLA_MIN         13'h000C
`define FLA_MAX         13'h1F40
`define GF_LVL_MIN      7'h02
`define GF_LVL_MAX      7'h64
`define GF_DLY_MIN      5'h05
`define GF_DLY_MAX      5'h19
`define JAM_MIN         8'h64
`define JAM_MAX         8'hFA
`define JAM_DLY_MAX     8'hC8
`define JAM_STEP_TICKS  16'h0032
`define STALL_MIN       10'h14A
`define STALL_MAX       10'h258
`define STALL_DLY_MAX   6'h3C
`define STALL_STEP_TICKS 16'h0005
`define UNBAL_MIN       5'h02
`define UNBAL_MAX       5'h19
`define LOAD_MIN        7'h0F
`define LOAD_MAX        7'h64
`define SEC_STEP_TICKS  16'h000A
`define AUX_DLY_MAX     8'hFA
`define CPT_SEL_MAX     4'hB
`define CT_SEL_MAX      4'hD
`define PF_NOM_MILLI    10'h352
`define CPT_SEC_VOLTS   32'h00000078

`endif

// ==== logic/motor_fault_pkg.sv ====
package motor_fault_pkg;
	typedef enum logic [2:0] {
		full_voltage_nonreversing_starter,
		full_voltage_reversing_starter,
		reversing_starter,
		two_speed_single_winding,
		two_speed_dual_winding,
		custom_starter
	} starter_t;

	typedef struct packed {
		logic [15:0] phase_a;
		logic [15:0] phase_b;
		logic [15:0] phase_c;
		logic [15:0] ground;
		logic [15:0] voltage;
		logic [6:0]  pf_angle;
		logic        contactor_feedback_one;
		logic        contactor_feedback_two;
	} meas_t;

	typedef struct packed {
		logic ground;
		logic jam;
		logic stall;
		logic unbal;
		logic load_loss;
		logic aux;
		logic overcurrent;
	} faults_t;

	typedef struct packed {
		logic        cfg_access;
		logic        run_cmd;
		logic        run2;
		logic [3:0]  cpt_sel;
		logic [3:0]  ct_sel;
		logic [1:0]  turns_m1;
		starter_t    starter;
		logic [12:0] fla1;
		logic [12:0] fla2;
		logic [6:0]  gf_lvl;
		logic [4:0]  gf_dly;
		logic [7:0]  jam_lvl;
		logic [7:0]  jam_dly;
		logic [9:0]  stall_lvl;
		logic [5:0]  stall_dly;
		logic [4:0]  unbal_lvl;
		logic [7:0]  unbal_dly;
		logic [6:0]  load_lvl;
		logic [7:0]  load_dly;
		logic [7:0]  aux_dly;
	} settings_t;
endpackage

// ==== logic/motor_fault_protection.sv ====
`timescale 1ns/1ns
`include "motor_fault_defines.svh"
// Functional notes
// - control power transformer ratio resets to 240:120 until software picks another
// - current selections 0 and 1 are sensor packs, the rest external CT ratios
// - turns 1 to 4 scale the effective CT ratio
// - two speed single winding: run 2 derived from run 1 at 4:1
// - two speed dual winding: run 2 derived from run 1 at 2:1
// - run 2 edits refused unless custom starter, even in configuration access
// - full load current accepted only from 1.2 to 800 A
// - full load current above the CT or pack rating refused, lower accepted
// - ground fault trips after current exceeds setpoint for 0.5 to 2.5 s
// - jam threshold 100 to 250 percent or off, off by default
// - overcurrent curve trip is always active, never disabled
// - stall threshold 330 to 600 percent or off, off by default
// - unbalance uses phase currents, full load current, CT ratio and turns
// - unbalance is largest deviation from average over reference, times 100
// - average replaces full load current as reference when larger
// - unbalance threshold 2 to 25 percent, off by default
// - load power is 1.732 times average current, voltage and power factor
// - power factor from voltage to phase C current angle
// - full load power at full load current, nominal voltage, factor 0.85
// - load loss only after power stays low for whole delay, off by default
// - contactor feedback mismatch past delay records fault, drops run relay
// - closing check delay configurable default 0.4 s, opening fixed 0.4 s
// - jam delay 0 to 1000 s in 5 s steps, default 120 s
// - stall delay 0 to 30 s in half second steps, default 10 s
module motor_fault_protection #(
	parameter int TICK_CYCLES = `TICK_NS / `CLK_PERIOD_NS
) (
	input  wire logic                   i_clk,
	input  wire logic                   i_rst,
	input  wire logic                   i_psel,
	input  wire logic                   i_penable,
	input  wire logic                   i_pwrite,
	input  wire logic [7:0]             i_paddr,
	input  wire logic [31:0]            i_pwdata,
	output logic [31:0]                 o_prdata,
	output logic                        o_pready,
	output logic                        o_pslverr,
	input  wire motor_fault_pkg::meas_t i_meas,
	input  wire logic                   i_overcurrent_trip,
	output logic                        o_run_relay,
	output logic                        o_ground_fault_relay,
	output logic                        o_trip,
	output motor_fault_pkg::faults_t    o_faults
);
	localparam int CNT_W = $clog2(TICK_CYCLES);
	localparam int N_TMR = 7;
	localparam logic [15:0] AUX_OPEN_TICKS = 16'(`AUX_OPEN_MS / `TICK_MS);
	localparam motor_fault_pkg::settings_t RST_CFG = '{
		cfg_access: 1'b0, run_cmd: 1'b0, run2: 1'b0,
		cpt_sel: `RST_CPT_SEL, ct_sel: `RST_CT_SEL, turns_m1: 2'h0,
		starter: motor_fault_pkg::full_voltage_nonreversing_starter,
		fla1: `RST_FLA, fla2: `RST_FLA, gf_lvl: 7'h00, gf_dly: `RST_GF_DLY,
		jam_lvl: 8'h00, jam_dly: `RST_JAM_DLY, stall_lvl: 10'h000, stall_dly: `RST_STALL_DLY,
		unbal_lvl: 5'h00, unbal_dly: `RST_UNBAL_DLY, load_lvl: 7'h00, load_dly: `RST_LOAD_DLY,
		aux_dly: `RST_AUX_DLY};

	motor_fault_pkg::settings_t cfg_ff, nxt_cfg;
	motor_fault_pkg::meas_t     meas_s1_ff, meas_s2_ff;
	motor_fault_pkg::faults_t   faults_ff, nxt_faults, new_faults;
	logic [CNT_W-1:0]           tick_cnt_ff, nxt_tick_cnt;
	logic                       tick_ff, nxt_tick;
	logic [15:0]                tmr_ff [N_TMR];
	logic [15:0]                nxt_tmr [N_TMR];
	logic [15:0]                lim [N_TMR];
	logic [N_TMR-1:0]           cond, expd;
	logic [31:0]                prdata_ff, nxt_prdata, rd_val;
	logic                       pready_ff, nxt_pready, pslverr_ff, nxt_pslverr;
	logic                       relay_ff, nxt_relay, gf_relay_ff, nxt_gf_relay, trip_ff, nxt_trip;
	logic                       wr_ok, rd_ok, commit, clr_req, fb;
	logic [23:0]                ia, ib, ic, avg, maxdev, ref_cur;
	logic [12:0]                fla2_eff, fla_act;
	logic [15:0]                line_v;
	logic [9:0]                 pf;

	function automatic logic [9:0] rating_amps(input logic [3:0] sel);
		case (sel)
			4'h0: rating_amps = 10'h01B;
			4'h1: rating_amps = 10'h05A;
			4'h2: rating_amps = 10'h04B;
			4'h3: rating_amps = 10'h064;
			4'h4: rating_amps = 10'h096;
			4'h5: rating_amps = 10'h0C8;
			4'h6: rating_amps = 10'h0E1;
			4'h7: rating_amps = 10'h0FA;
			4'h8: rating_amps = 10'h12C;
			4'h9: rating_amps = 10'h190;
			4'hA: rating_amps = 10'h1F4;
			4'hB: rating_amps = 10'h258;
			4'hC: rating_amps = 10'h2BC;
			default: rating_amps = 10'h320;
		endcase
	endfunction

	function automatic logic [12:0] cpt_volts(input logic [3:0] sel);
		case (sel)
			4'h0: cpt_volts = 13'h00C8;
			4'h1: cpt_volts = 13'h00F0;
			4'h2: cpt_volts = 13'h01E0;
			4'h3: cpt_volts = 13'h0258;
			4'h4: cpt_volts = 13'h0960;
			4'h5: cpt_volts = 13'h0BB8;
			4'h6: cpt_volts = 13'h0CE4;
			4'h7: cpt_volts = 13'h1068;
			4'h8: cpt_volts = 13'h12C0;
			4'h9: cpt_volts = 13'h1518;
			4'hA: cpt_volts = 13'h1770;
			default: cpt_volts = 13'h1C20;
		endcase
	endfunction

	// coarse 10 degree steps; good enough for a trip threshold
	function automatic logic [9:0] cos_milli(input logic [6:0] angle);
		case (angle / 7'h0A)
			7'h00: cos_milli = 10'h3E8;
			7'h01: cos_milli = 10'h3D9;
			7'h02: cos_milli = 10'h3AC;
			7'h03: cos_milli = 10'h362;
			7'h04: cos_milli = 10'h2FE;
			7'h05: cos_milli = 10'h283;
			7'h06: cos_milli = 10'h1F4;
			7'h07: cos_milli = 10'h156;
			7'h08: cos_milli = 10'h0AE;
			default: cos_milli = 10'h000;
		endcase
	endfunction

	function automatic logic [23:0] to_primary(input logic [15:0] sec, input logic [3:0] ct, input logic [1:0] tm1);
		logic [25:0] num;
		logic [25:0] den;
		num = {10'h000, sec};
		den = {24'h000000, tm1} + 26'h0000001;
		if (ct > 4'h1) begin
			num = {10'h000, sec} * {16'h0000, rating_amps(ct)};
			den = den * 26'h0000005;
		end
		to_primary = 24'(num / den);
	endfunction

	function automatic logic fla_fits(input logic [12:0] full_load_current, input logic [3:0] ct, input logic [1:0] tm1);
		logic [17:0] lhs;
		logic [17:0] rhs;
		lhs = {5'h00, full_load_current} * ({16'h0000, tm1} + 18'h00001);
		rhs = {8'h00, rating_amps(ct)} * 18'h0000A;
		fla_fits = lhs <= rhs;
	endfunction

	function automatic logic lvl_ok(input logic [9:0] v, input logic [9:0] lo, input logic [9:0] hi);
		lvl_ok = (v == 10'h000) || (v >= lo && v <= hi);
	endfunction

	function automatic logic [23:0] absdiff(input logic [23:0] a, input logic [23:0] b);
		absdiff = (a > b) ? a - b : b - a;
	endfunction

	function automatic logic [15:0] tmr_step(input logic c, input logic t, input logic [15:0] cnt);
		if (!c) begin
			tmr_step = 16'h0000;
		end else if (t && cnt != 16'hFFFF) begin
			tmr_step = cnt + 16'h0001;
		end else begin
			tmr_step = cnt;
		end
	endfunction

	// run 2 full load current
	always_comb begin
		unique case (cfg_ff.starter)
			motor_fault_pkg::two_speed_single_winding: fla2_eff = {2'h0, cfg_ff.fla1[12:2]};
			motor_fault_pkg::two_speed_dual_winding: fla2_eff = {1'h0, cfg_ff.fla1[12:1]};
			motor_fault_pkg::custom_starter: fla2_eff = cfg_ff.fla2;
			default: fla2_eff = cfg_ff.fla1;
		endcase
	end

	// register bus
	always_comb begin
		nxt_cfg = cfg_ff;
		nxt_pready = i_psel && i_penable && !pready_ff;
		nxt_pslverr = 1'b0;
		nxt_prdata = 32'h00000000;
		commit = i_psel && i_penable && pready_ff && i_pwrite && !pslverr_ff;
		clr_req = 1'b0;
		rd_val = 32'h00000000;
		rd_ok = 1'b1;
		wr_ok = 1'b0;
		case (i_paddr)
			`ADDR_CTRL: begin
				rd_val = {29'h00000000, cfg_ff.run2, cfg_ff.run_cmd, cfg_ff.cfg_access};
				wr_ok = 1'b1;
			end
			`ADDR_XFMR: begin
				rd_val = {22'h000000, cfg_ff.turns_m1, cfg_ff.ct_sel, cfg_ff.cpt_sel};
				// new rating must still cover the setting
				wr_ok = cfg_ff.cfg_access && i_pwdata[`F_XF_CPT +: 4] <= `CPT_SEL_MAX
					&& i_pwdata[`F_XF_CT +: 4] <= `CT_SEL_MAX
					&& fla_fits(cfg_ff.fla1, i_pwdata[`F_XF_CT +: 4], i_pwdata[`F_XF_TURNS +: 2])
					&& fla_fits(fla2_eff, i_pwdata[`F_XF_CT +: 4], i_pwdata[`F_XF_TURNS +: 2]);
			end
			`ADDR_STARTER: begin
				rd_val = {29'h00000000, cfg_ff.starter};
				wr_ok = cfg_ff.cfg_access && i_pwdata[2:0] <= 3'h5;
			end
			`ADDR_FLA1: begin
				rd_val = {19'h00000, cfg_ff.fla1};
				wr_ok = cfg_ff.cfg_access && i_pwdata[12:0] >= `FLA_MIN && i_pwdata[12:0] <= `FLA_MAX
					&& fla_fits(i_pwdata[12:0], cfg_ff.ct_sel, cfg_ff.turns_m1);
			end
			`ADDR_FLA2: begin
				rd_val = {19'h00000, fla2_eff};
				wr_ok = cfg_ff.cfg_access && cfg_ff.starter == motor_fault_pkg::custom_starter
					&& i_pwdata[12:0] >= `FLA_MIN && i_pwdata[12:0] <= `FLA_MAX
					&& fla_fits(i_pwdata[12:0], cfg_ff.ct_sel, cfg_ff.turns_m1);
			end
			`ADDR_GROUND: begin
				rd_val = {11'h000, cfg_ff.gf_dly, 9'h000, cfg_ff.gf_lvl};
				wr_ok = cfg_ff.cfg_access && lvl_ok(10'(i_pwdata[6:0]), 10'(`GF_LVL_MIN), 10'(`GF_LVL_MAX))
					&& i_pwdata[`F_DLY +: 5] >= `GF_DLY_MIN && i_pwdata[`F_DLY +: 5] <= `GF_DLY_MAX;
			end
			`ADDR_JAM: begin
				rd_val = {8'h00, cfg_ff.jam_dly, 8'h00, cfg_ff.jam_lvl};
				wr_ok = cfg_ff.cfg_access && lvl_ok(10'(i_pwdata[7:0]), 10'(`JAM_MIN), 10'(`JAM_MAX))
					&& i_pwdata[`F_DLY +: 8] <= `JAM_DLY_MAX;
			end
			`ADDR_STALL: begin
				rd_val = {10'h000, cfg_ff.stall_dly, 6'h00, cfg_ff.stall_lvl};
				wr_ok = cfg_ff.cfg_access && lvl_ok(i_pwdata[9:0], `STALL_MIN, `STALL_MAX)
					&& i_pwdata[`F_DLY +: 6] <= `STALL_DLY_MAX;
			end
			`ADDR_UNBAL: begin
				rd_val = {8'h00, cfg_ff.unbal_dly, 11'h000, cfg_ff.unbal_lvl};
				wr_ok = cfg_ff.cfg_access && lvl_ok(10'(i_pwdata[4:0]), 10'(`UNBAL_MIN), 10'(`UNBAL_MAX));
			end
			`ADDR_LOAD: begin
				rd_val = {8'h00, cfg_ff.load_dly, 9'h000, cfg_ff.load_lvl};
				wr_ok = cfg_ff.cfg_access && lvl_ok(10'(i_pwdata[6:0]), 10'(`LOAD_MIN), 10'(`LOAD_MAX));
			end
			`ADDR_AUX: begin
				rd_val = {24'h000000, cfg_ff.aux_dly};
				wr_ok = cfg_ff.cfg_access && i_pwdata[7:0] <= `AUX_DLY_MAX;
			end
			`ADDR_STATUS: rd_val = {17'h00000, faults_ff, 4'h0, cfg_ff.cfg_access, gf_relay_ff, trip_ff, relay_ff};
			`ADDR_METER: rd_val = {line_v, avg[15:0]};
			default: rd_ok = 1'b0;
		endcase
		if (nxt_pready) begin
			nxt_pslverr = i_pwrite ? !wr_ok : !rd_ok;
			nxt_prdata = i_pwrite ? 32'h00000000 : rd_val;
		end
		if (commit) begin
			case (i_paddr)
				`ADDR_CTRL: begin
					nxt_cfg.cfg_access = i_pwdata[`F_CTRL_CFG];
					nxt_cfg.run_cmd = i_pwdata[`F_CTRL_RUN];
					nxt_cfg.run2 = i_pwdata[`F_CTRL_RUN2];
					clr_req = i_pwdata[`F_CTRL_CLR];
				end
				`ADDR_XFMR: begin
					nxt_cfg.cpt_sel = i_pwdata[`F_XF_CPT +: 4];
					nxt_cfg.ct_sel = i_pwdata[`F_XF_CT +: 4];
					nxt_cfg.turns_m1 = i_pwdata[`F_XF_TURNS +: 2];
				end
				`ADDR_STARTER: nxt_cfg.starter = motor_fault_pkg::starter_t'(i_pwdata[2:0]);
				`ADDR_FLA1: nxt_cfg.fla1 = i_pwdata[12:0];
				`ADDR_FLA2: nxt_cfg.fla2 = i_pwdata[12:0];
				`ADDR_GROUND: begin
					nxt_cfg.gf_lvl = i_pwdata[6:0];
					nxt_cfg.gf_dly = i_pwdata[`F_DLY +: 5];
				end
				`ADDR_JAM: begin
					nxt_cfg.jam_lvl = i_pwdata[7:0];
					nxt_cfg.jam_dly = i_pwdata[`F_DLY +: 8];
				end
				`ADDR_STALL: begin
					nxt_cfg.stall_lvl = i_pwdata[9:0];
					nxt_cfg.stall_dly = i_pwdata[`F_DLY +: 6];
				end
				`ADDR_UNBAL: begin
					nxt_cfg.unbal_lvl = i_pwdata[4:0];
					nxt_cfg.unbal_dly = i_pwdata[`F_DLY +: 8];
				end
				`ADDR_LOAD: begin
					nxt_cfg.load_lvl = i_pwdata[6:0];
					nxt_cfg.load_dly = i_pwdata[`F_DLY +: 8];
				end
				`ADDR_AUX: nxt_cfg.aux_dly = i_pwdata[7:0];
				default: nxt_cfg = cfg_ff;
			endcase
		end
	end

	// measurement and protection
	always_comb begin
		nxt_tick = tick_cnt_ff == CNT_W'(TICK_CYCLES - 1);
		nxt_tick_cnt = nxt_tick ? '0 : tick_cnt_ff + CNT_W'(1);
		ia = to_primary(meas_s2_ff.phase_a, cfg_ff.ct_sel, cfg_ff.turns_m1);
		ib = to_primary(meas_s2_ff.phase_b, cfg_ff.ct_sel, cfg_ff.turns_m1);
		ic = to_primary(meas_s2_ff.phase_c, cfg_ff.ct_sel, cfg_ff.turns_m1);
		avg = 24'(({2'h0, ia} + {2'h0, ib} + {2'h0, ic}) / 26'h0000003);
		maxdev = absdiff(ia, avg);
		if (absdiff(ib, avg) > maxdev) begin
			maxdev = absdiff(ib, avg);
		end
		if (absdiff(ic, avg) > maxdev) begin
			maxdev = absdiff(ic, avg);
		end
		fla_act = cfg_ff.run2 ? fla2_eff : cfg_ff.fla1;
		ref_cur = (avg > {11'h000, fla_act}) ? avg : {11'h000, fla_act};
		line_v = 16'(({16'h0000, meas_s2_ff.voltage} * {19'h00000, cpt_volts(cfg_ff.cpt_sel)}) / `CPT_SEC_VOLTS);
		// factor from voltage to phase C angle
		pf = cos_milli(meas_s2_ff.pf_angle);
		fb = cfg_ff.run2 ? meas_s2_ff.contactor_feedback_two : meas_s2_ff.contactor_feedback_one;
		cond[0] = cfg_ff.gf_lvl != 7'h00 && meas_s2_ff.ground > {8'h00, cfg_ff.gf_lvl, 1'b0};
		// jam above percent of full load
		cond[1] = cfg_ff.jam_lvl != 8'h00 && 40'(avg) * 40'h64 > 40'(fla_act) * 40'(cfg_ff.jam_lvl);
		// stall above percent of full load
		cond[2] = cfg_ff.stall_lvl != 10'h000 && 40'(avg) * 40'h64 > 40'(fla_act) * 40'(cfg_ff.stall_lvl);
		cond[3] = relay_ff && cfg_ff.unbal_lvl != 5'h00
			&& 40'(maxdev) * 40'h64 > 40'(ref_cur) * 40'(cfg_ff.unbal_lvl);
		// power times 1.732 on both sides cancels
		// full load at nominal voltage and 0.85
		cond[4] = relay_ff && cfg_ff.load_lvl != 7'h00
			&& 64'(avg) * 64'(line_v) * 64'(pf) * 64'h64
			< 64'(fla_act) * 64'(cpt_volts(cfg_ff.cpt_sel)) * 64'(`PF_NOM_MILLI) * 64'(cfg_ff.load_lvl);
		cond[5] = relay_ff && !fb && cfg_ff.aux_dly != 8'h00;
		cond[6] = !relay_ff && fb;
		lim[0] = {11'h000, cfg_ff.gf_dly};
		// jam delay in 5 s steps
		lim[1] = 16'({8'h00, cfg_ff.jam_dly} * `JAM_STEP_TICKS);
		lim[2] = 16'({10'h000, cfg_ff.stall_dly} * `STALL_STEP_TICKS);
		lim[3] = 16'({8'h00, cfg_ff.unbal_dly} * `SEC_STEP_TICKS);
		lim[4] = 16'({8'h00, cfg_ff.load_dly} * `SEC_STEP_TICKS);
		lim[5] = {8'h00, cfg_ff.aux_dly};
		lim[6] = AUX_OPEN_TICKS;
		for (int k = 0; k < N_TMR; k++) begin
			nxt_tmr[k] = tmr_step(cond[k], tick_ff, tmr_ff[k]);
			// only an unbroken condition for the whole delay
			expd[k] = cond[k] && (lim[k] == 16'h0000 || tmr_ff[k] > lim[k]);
		end
		new_faults.ground = expd[0];
		new_faults.jam = expd[1];
		new_faults.stall = expd[2];
		new_faults.unbal = expd[3];
		new_faults.load_loss = expd[4];
		new_faults.aux = expd[5] || expd[6];
		new_faults.overcurrent = i_overcurrent_trip;
		// latched until cleared or reset, a new event beats the clear
		nxt_faults = (clr_req ? '0 : faults_ff) | new_faults;
		nxt_trip = |nxt_faults;
		// run relay held off while any trip stands
		nxt_relay = cfg_ff.run_cmd && !cfg_ff.cfg_access && !nxt_trip;
		nxt_gf_relay = nxt_faults.ground;
	end

	always_ff @(posedge i_clk) begin
		meas_s1_ff <= i_meas;
		meas_s2_ff <= meas_s1_ff;
		if (i_rst) begin
			cfg_ff <= RST_CFG;
			faults_ff <= '0;
			tick_cnt_ff <= '0;
			tick_ff <= 1'b0;
			prdata_ff <= 32'h00000000;
			pready_ff <= 1'b0;
			pslverr_ff <= 1'b0;
			relay_ff <= 1'b0;
			gf_relay_ff <= 1'b0;
			trip_ff <= 1'b0;
			for (int k = 0; k < N_TMR; k++) begin
				tmr_ff[k] <= 16'h0000;
			end
		end else begin
			cfg_ff <= nxt_cfg;
			faults_ff <= nxt_faults;
			tick_cnt_ff <= nxt_tick_cnt;
			tick_ff <= nxt_tick;
			prdata_ff <= nxt_prdata;
			pready_ff <= nxt_pready;
			pslverr_ff <= nxt_pslverr;
			relay_ff <= nxt_relay;
			gf_relay_ff <= nxt_gf_relay;
			trip_ff <= nxt_trip;
			for (int k = 0; k < N_TMR; k++) begin
				tmr_ff[k] <= nxt_tmr[k];
			end
		end
	end

	assign o_prdata = prdata_ff;
	assign o_pready = pready_ff;
	assign o_pslverr = pslverr_ff;
	assign o_run_relay = relay_ff;
	assign o_ground_fault_relay = gf_relay_ff;
	assign o_trip = trip_ff;
	assign o_faults = faults_ff;
endmodule // motor_fault_protection

// ==== bench/motor_fault_checker.sv ====
`timescale 1ns/1ns
`include "motor_fault_defines.svh"
module motor_fault_checker (
	input wire logic                     i_clk,
	input wire logic                     i_rst,
	input wire logic                     i_psel,
	input wire logic                     i_penable,
	input wire logic                     i_pwrite,
	input wire logic [7:0]               i_paddr,
	input wire logic [31:0]              i_pwdata,
	input wire logic [31:0]              o_prdata,
	input wire logic                     o_pready,
	input wire logic                     o_pslverr,
	input wire motor_fault_pkg::meas_t   i_meas,
	input wire logic                     i_overcurrent_trip,
	input wire logic                     o_run_relay,
	input wire logic                     o_ground_fault_relay,
	input wire logic                     o_trip,
	input wire motor_fault_pkg::faults_t o_faults
);
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_rst);
	a_ready_pulse: assert property (o_pready |=> !o_pready) else $error("pready longer than one cycle");
	a_one_wait: assert property ((i_psel && !i_penable) ##1 (i_psel && i_penable) |=> o_pready)
		else $error("pready not after one wait state");
	a_no_stray: assert property (!i_penable |=> !o_pready) else $error("pready without access");
	a_err_ready: assert property (o_pslverr |-> o_pready) else $error("pslverr outside pready");
	a_idle_data: assert property (!o_pready |-> o_prdata == 32'h0) else $error("prdata not zero when idle");
	a_relay_trip: assert property (o_trip |-> !o_run_relay)
		else $error("run relay on during trip");
	a_trip_any: assert property (o_trip == (|o_faults))
		else $error("trip differs from faults");
	a_gf_relay: assert property (o_ground_fault_relay == o_faults.ground)
		else $error("ground relay differs from fault");
	a_oc_latch: assert property (i_overcurrent_trip |=> o_faults.overcurrent)
		else $error("overcurrent not latched");
	// clear lands at the commit edge, so the write is one sample back
	a_clear_only: assert property ($fell(o_trip) |->
		$past(o_pready && i_pwrite && i_paddr == `ADDR_CTRL && i_pwdata[`F_CTRL_CLR]))
		else $error("trip dropped without clear");
	a_gf_cause: assert property ($rose(o_faults.ground) |-> $past(i_meas.ground, 3) != 16'h0000)
		else $error("ground trip without ground current");
endmodule // motor_fault_checker

// ==== bench/motor_feed_model.sv ====
`timescale 1ns/1ns
module motor_feed_model (
	input  wire logic               i_clk,
	input  wire logic               i_run_relay,
	input  wire logic [47:0]        i_phases,
	input  wire logic [15:0]        i_ground,
	output motor_fault_pkg::meas_t  o_meas
);
	logic [2:0] fb_ff;
	// contacts follow relay
	// pickup and dropout in 3 cycles, well inside the check delay
	always_ff @(posedge i_clk) fb_ff <= {fb_ff[1:0], i_run_relay};
	// fixed 120 V secondary and a lagging angle near 0.85
	assign o_meas = {i_phases, i_ground, 16'h0078, 7'h20, fb_ff[2], fb_ff[2]};
endmodule // motor_feed_model

// ==== bench/tb_motor_fault_protection.sv ====
`timescale 1ns/1ns
`include "motor_fault_defines.svh"
module tb_motor_fault_protection;
	logic                     i_clk, i_rst, i_psel, i_penable, i_pwrite, i_overcurrent_trip;
	logic                     o_pready, o_pslverr, o_run_relay, o_ground_fault_relay, o_trip;
	logic [7:0]               i_paddr;
	logic [31:0]              i_pwdata, o_prdata;
	logic [15:0]              gnd;
	logic [47:0]              phs;
	logic [33:0]              exp_q[$];
	logic [33:0]              e;
	motor_fault_pkg::meas_t   i_meas;
	motor_fault_pkg::faults_t o_faults;
	int                       err_count, tests_run, cyc, seed, n, s;
	motor_feed_model u_feed (.i_clk, .i_run_relay(o_run_relay), .i_phases(phs), .i_ground(gnd), .o_meas(i_meas));
	motor_fault_protection #(.TICK_CYCLES(4)) u_dut (.i_clk, .i_rst, .i_psel, .i_penable, .i_pwrite, .i_paddr,
		.i_pwdata, .o_prdata, .o_pready, .o_pslverr, .i_meas, .i_overcurrent_trip, .o_run_relay,
		.o_ground_fault_relay, .o_trip, .o_faults);
	initial begin
		i_clk = 0;
		forever #2 i_clk = ~i_clk;
	end
	task end_sim;
		$display("comparisons %0d mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	task check(input string nm, input logic [31:0] ex, input logic [31:0] got);
		tests_run++;
		if (got !== ex) begin
			err_count++;
			$display("unexpected %s expected %0h seen %0h", nm, ex, got);
		end
	endtask
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [33:0] ex);
		exp_q.push_back(ex);
		@(posedge i_clk);
		{i_psel, i_penable, i_pwrite, i_paddr, i_pwdata} <= {2'b10, w, a, d};
		@(posedge i_clk);
		i_penable <= 1'b1;
		n = 0;
		do begin
			@(posedge i_clk);
			n++;
		end while (o_pready !== 1'b1 && n < 20);
		{i_psel, i_penable} <= 2'b00;
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d, input logic err);
		apb(1'b1, a, d, {1'b0, err, 32'h0});
	endtask
	task rd(input logic [7:0] a, input logic [31:0] ex);
		apb(1'b0, a, 32'h0, {2'b10, ex});
	endtask
	// oldest note meets the answer in its one pready cycle
	always @(posedge i_clk) begin
		if (o_pready === 1'b1) begin
			e = exp_q.pop_front();
			check("pslverr", {31'h0, e[32]}, {31'h0, o_pslverr});
			if (e[33]) check("prdata", e[31:0], o_prdata);
		end
	end
	always @(posedge i_clk) begin
		phs <= {16'h01F4 + 16'($random(seed) & 7), 16'h01F4 + 16'($random(seed) & 7), 16'h01F4};
		cyc++;
		if (cyc > 20000) begin
			err_count++;
			end_sim();
		end
	end
	initial begin
		seed = 33;
		{i_rst, i_psel, i_penable, i_pwrite, i_overcurrent_trip} = 5'b10000;
		{i_paddr, i_pwdata, gnd, phs} = '0;
		repeat (8) @(posedge i_clk);
		i_rst <= 1'b0;
		rd(`ADDR_XFMR, 32'h00000031);
		apb(1'b0, 8'h40, 32'h0, {2'b01, 32'h0});
		wr(`ADDR_FLA1, 32'h000001F4, 1'b1);
		wr(`ADDR_CTRL, 32'h00000001, 1'b0);
		wr(`ADDR_FLA1, 32'h0000000B, 1'b1);
		wr(`ADDR_FLA1, 32'h000003E9, 1'b1);
		wr(`ADDR_XFMR, 32'h00000131, 1'b1);
		wr(`ADDR_XFMR, 32'h000000E1, 1'b1);
		wr(`ADDR_FLA1, 32'h000001F4, 1'b0);
		wr(`ADDR_XFMR, 32'h00000131, 1'b0);
		wr(`ADDR_FLA1, 32'h000001F5, 1'b1);
		for (s = 0; s < 5; s++) begin
			wr(`ADDR_STARTER, s, 1'b0);
			rd(`ADDR_FLA2, s == 3 ? 32'h7D : s == 4 ? 32'hFA : 32'h1F4);
			wr(`ADDR_FLA2, 32'h00000064, 1'b1);
		end
		wr(`ADDR_STARTER, 32'h00000005, 1'b0);
		wr(`ADDR_FLA2, 32'h00000064, 1'b0);
		rd(`ADDR_FLA2, 32'h00000064);
		wr(`ADDR_GROUND, 32'h00040005, 1'b1);
		wr(`ADDR_GROUND, 32'h00050005, 1'b0);
		wr(`ADDR_CTRL, 32'h00000002, 1'b0);
		repeat (4) @(posedge i_clk);
		check("run_relay", 1, o_run_relay);
		$display("test settings done");
		// short bursts stay under the five tick delay
		repeat (2) begin
			gnd <= 16'h0014;
			repeat (12) @(posedge i_clk);
			gnd <= 16'h0000;
			repeat (4) @(posedge i_clk);
		end
		check("gf_relay", 0, o_ground_fault_relay);
		gnd <= 16'h0014;
		n = 0;
		while (o_ground_fault_relay !== 1'b1 && n < 200) begin
			@(posedge i_clk);
			n++;
		end
		check("gf_time_ok", 1, n >= 20 && n <= 30);
		gnd <= 16'h0000;
		repeat (8) @(posedge i_clk);
		check("trip_relay", 32'h2, {o_trip, o_run_relay});
		wr(`ADDR_CTRL, 32'h0000000A, 1'b0);
		repeat (3) @(posedge i_clk);
		check("cleared", 32'h1, {o_trip, o_run_relay});
		$display("test ground done");
		i_overcurrent_trip <= 1'b1;
		repeat (2) @(posedge i_clk);
		i_overcurrent_trip <= 1'b0;
		repeat (2) @(posedge i_clk);
		check("oc_fault", 32'h2, {o_faults.overcurrent, o_run_relay});
		rd(`ADDR_STATUS, 32'h00000102);
		repeat (2) @(posedge i_clk);
		check("queue_empty", 0, exp_q.size());
		$display("test overcurrent done");
		end_sim();
	end
endmodule // tb_motor_fault_protection
bind motor_fault_protection motor_fault_checker u_chk (.i_clk, .i_rst, .i_psel, .i_penable, .i_pwrite, .i_paddr,
	.i_pwdata, .o_prdata, .o_pready, .o_pslverr, .i_meas, .i_overcurrent_trip, .o_run_relay,
	.o_ground_fault_relay, .o_trip, .o_faults);
